// ### shared/rgseq_regs.vh
// Register map, field positions, reset values and timing counts of the regulator sequencer.
`ifndef RGSEQ_REGS_VH
`define RGSEQ_REGS_VH
`define RGSEQ_ADDR_W 4
`define RGSEQ_CTRL_OFS 4'h0
`define RGSEQ_STATUS_OFS 4'h4
`define RGSEQ_CTRL_ORDER_LSB 0
`define RGSEQ_CTRL_VARIANT_BIT 2
`define RGSEQ_CTRL_RST 3'h0
`define RGSEQ_ST_TSD_BIT 0
`define RGSEQ_ST_UVLO_BIT 1
`define RGSEQ_ST_BUCK_ON_BIT 2
`define RGSEQ_ST_LDO_ON_BIT 3
`define RGSEQ_ST_CAUSE_LOW_BIT 4
`define RGSEQ_ST_PEND_BUCK_BIT 5
`define RGSEQ_ST_PEND_LDO_BIT 6
`define RGSEQ_ST_STATE_LSB 8
`define RGSEQ_ORDER_LDO_FIRST 2'h0
`define RGSEQ_ORDER_TOGETHER 2'h3
`define RGSEQ_RESP_OKAY 2'h0
`define RGSEQ_RESP_DECERR 2'h3
`define RGSEQ_CLK_HZ 50000000
`define RGSEQ_TICK_US 1000
`define RGSEQ_TICK_CYCLES (`RGSEQ_CLK_HZ / 1000000 * `RGSEQ_TICK_US)
`define RGSEQ_SEQ_DELAY_MS 2
`define RGSEQ_OFF_TIME_MS 2
`define RGSEQ_CAUSE_HOLD_MS 1000
`define RGSEQ_SEQ_TICKS (`RGSEQ_SEQ_DELAY_MS * 1000 / `RGSEQ_TICK_US)
`define RGSEQ_OFF_TICKS (`RGSEQ_OFF_TIME_MS * 1000 / `RGSEQ_TICK_US)
`define RGSEQ_CAUSE_TICKS (`RGSEQ_CAUSE_HOLD_MS * 1000 / `RGSEQ_TICK_US)
`endif

// ### rtl/rgseq_tick.v
// Internal oscillator divider giving a one-cycle time-base enable pulse.
`timescale 1ns/100ps
module rgseq_tick #(
   parameter TICK_CYCLES = 50000
) (
   input wire i_clock,
   input wire i_rst,
   input wire i_sync,
   output reg o_tick
);
   reg [16:0] count_reg;

   always @(posedge i_clock) begin
      if (i_rst || i_sync) begin
         count_reg <= 17'h00000;
         o_tick <= 1'b0;
      end else if (count_reg == TICK_CYCLES[16:0] - 17'h00001) begin
         count_reg <= 17'h00000;
         o_tick <= 1'b1;
      end else begin
         count_reg <= count_reg + 17'h00001;
         o_tick <= 1'b0;
      end
   end
endmodule // rgseq_tick

// ### rtl/rgseq_top.v
// Regulator enable sequencer with protection gating and an AXI4-Lite register port.
`timescale 1ns/100ps
`include "rgseq_regs.vh"
module rgseq_top #(
   parameter TICK_CYCLES = `RGSEQ_TICK_CYCLES
) (
   input wire i_clock,
   input wire i_rst,
   input wire i_buck_enable_pin,
   input wire i_ldo_enable_pin,
   input wire i_mode_pin,
   input wire i_temp_above_150,
   input wire i_temp_below_130,
   input wire i_supply_below_2v15,
   input wire i_supply_below_3v65,
   input wire i_wd1_timeout,
   input wire i_wd2_power_cycle,
   input wire [3:0] i_awaddr,
   input wire i_awvalid,
   output wire o_awready,
   input wire [31:0] i_wdata,
   input wire [3:0] i_wstrb,
   input wire i_wvalid,
   output wire o_wready,
   output reg [1:0] o_bresp,
   output reg o_bvalid,
   input wire i_bready,
   input wire [3:0] i_araddr,
   input wire i_arvalid,
   output wire o_arready,
   output reg [31:0] o_rdata,
   output reg [1:0] o_rresp,
   output reg o_rvalid,
   input wire i_rready,
   output reg o_buck_switch_en,
   output reg o_buck_rectifier_en,
   output reg o_buck_forced_pwm,
   output reg o_buck_power_save_operation,
   output reg o_buck_soft_start,
   output reg o_ldo_en,
   output reg o_ldo_soft_start,
   output wire o_watchdog_cause_status_out,
   output wire o_watchdog_cause_status_oe_n
);
   localparam ST_IDLE = 2'h0;
   localparam ST_OFF = 2'h1;
   localparam ST_FIRST = 2'h2;
   localparam [9:0] SEQ_TICKS = `RGSEQ_SEQ_TICKS;
   localparam [9:0] OFF_TICKS = `RGSEQ_OFF_TICKS;
   localparam [9:0] CAUSE_TICKS = `RGSEQ_CAUSE_TICKS;

   // Order decode, shared by the sequencer steps.
   function ldo_first;
      input [1:0] code;
      begin
         ldo_first = (code == `RGSEQ_ORDER_LDO_FIRST);
      end
   endfunction

   function start_together;
      input [1:0] code;
      begin
         start_together = (code == `RGSEQ_ORDER_TOGETHER);
      end
   endfunction

   reg [2:0] ctrl_reg;
   reg tsd_reg;
   reg uvlo_reg;
   reg cause_low_reg;
   reg [9:0] cause_cnt_reg;
   reg [1:0] state_reg;
   reg [1:0] state_next;
   reg [9:0] seq_cnt_reg;
   reg pend_buck_reg;
   reg pend_ldo_reg;
   reg buck_cmd_q;
   reg ldo_cmd_q;
   reg aw_full_reg;
   reg w_full_reg;
   reg [3:0] aw_addr_reg;
   reg [31:0] w_data_reg;
   reg [3:0] w_strb_reg;
   wire tick;
   wire [1:0] order_code;
   wire uvlo_now;
   wire buck_cmd;
   wire ldo_cmd;
   wire seq_done;
   wire wr_fire;
   wire [31:0] status_word;

   assign order_code = ctrl_reg[`RGSEQ_CTRL_ORDER_LSB +: 2];

   rgseq_tick #(
      .TICK_CYCLES(TICK_CYCLES)
   ) u_tick (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_sync(i_wd2_power_cycle),
      .o_tick(tick)
   );

   // Thermal shutdown holds until the cool comparator reports below 130 C.
   always @(posedge i_clock) begin
      if (i_rst) begin
         tsd_reg <= 1'b0;
      end else if (i_temp_above_150) begin
         tsd_reg <= 1'b1;
      end else if (i_temp_below_130) begin
         tsd_reg <= 1'b0;
      end
   end

   // The variant bit picks which lockout comparator is in use.
   assign uvlo_now = ctrl_reg[`RGSEQ_CTRL_VARIANT_BIT] ? i_supply_below_3v65
                                                       : i_supply_below_2v15;

   always @(posedge i_clock) begin
      if (i_rst) begin
         uvlo_reg <= 1'b0;
      end else begin
         uvlo_reg <= uvlo_now;
      end
   end

   // Restart sequencer after a long watchdog power cycle.
   assign seq_done = tick && (seq_cnt_reg == SEQ_TICKS - 10'h001);

   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            state_next = ST_IDLE;
         end
         ST_OFF: begin
            if (tick && (seq_cnt_reg == OFF_TICKS - 10'h001)) begin
               if (start_together(order_code)) begin
                  state_next = ST_IDLE;
               end else begin
                  state_next = ST_FIRST;
               end
            end
         end
         ST_FIRST: begin
            if (seq_done) begin
               state_next = ST_IDLE;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
      if (i_wd2_power_cycle) begin
         state_next = ST_OFF;
      end
   end

   always @(posedge i_clock) begin
      if (i_rst) begin
         state_reg <= ST_IDLE;
         seq_cnt_reg <= 10'h000;
         pend_buck_reg <= 1'b0;
         pend_ldo_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         if (state_next != state_reg || i_wd2_power_cycle) begin
            seq_cnt_reg <= 10'h000;
         end else if (tick) begin
            seq_cnt_reg <= seq_cnt_reg + 10'h001;
         end
         if (i_wd2_power_cycle) begin
            pend_buck_reg <= 1'b1;
            pend_ldo_reg <= 1'b1;
         end else if (state_reg == ST_OFF && state_next == ST_IDLE) begin
            pend_buck_reg <= 1'b0;
            pend_ldo_reg <= 1'b0;
         end else if (state_reg == ST_OFF && state_next == ST_FIRST) begin
            if (ldo_first(order_code)) begin
               pend_ldo_reg <= 1'b0;
            end else begin
               pend_buck_reg <= 1'b0;
            end
         end else if (state_reg == ST_FIRST && state_next == ST_IDLE) begin
            pend_buck_reg <= 1'b0;
            pend_ldo_reg <= 1'b0;
         end
      end
   end

   // On-commands: pin level gated by every shutdown source.
   assign buck_cmd = i_buck_enable_pin && !tsd_reg && !uvlo_reg && !pend_buck_reg;
   assign ldo_cmd = i_ldo_enable_pin && !tsd_reg && !uvlo_reg && !pend_ldo_reg;

   // A rising on-command starts the soft start, also when thermal shutdown ends.
   always @(posedge i_clock) begin
      if (i_rst) begin
         buck_cmd_q <= 1'b0;
         ldo_cmd_q <= 1'b0;
         o_buck_switch_en <= 1'b0;
         o_buck_rectifier_en <= 1'b0;
         o_buck_forced_pwm <= 1'b0;
         o_buck_power_save_operation <= 1'b0;
         o_buck_soft_start <= 1'b0;
         o_ldo_en <= 1'b0;
         o_ldo_soft_start <= 1'b0;
      end else begin
         buck_cmd_q <= buck_cmd;
         ldo_cmd_q <= ldo_cmd;
         o_buck_switch_en <= buck_cmd;
         o_buck_rectifier_en <= buck_cmd;
         o_ldo_en <= ldo_cmd;
         o_buck_soft_start <= buck_cmd && !buck_cmd_q;
         o_ldo_soft_start <= ldo_cmd && !ldo_cmd_q;
         o_buck_forced_pwm <= buck_cmd && i_mode_pin;
         o_buck_power_save_operation <= buck_cmd && !i_mode_pin;
      end
   end

   // Watchdog cause: driven low for one second after a long watchdog event, released early by a short watchdog timeout.
   always @(posedge i_clock) begin
      if (i_rst) begin
         cause_low_reg <= 1'b0;
         cause_cnt_reg <= 10'h000;
      end else if (i_wd2_power_cycle) begin
         cause_low_reg <= 1'b1;
         cause_cnt_reg <= 10'h000;
      end else if (i_wd1_timeout) begin
         cause_low_reg <= 1'b0;
         cause_cnt_reg <= 10'h000;
      end else if (cause_low_reg && tick) begin
         if (cause_cnt_reg == CAUSE_TICKS - 10'h001) begin
            cause_low_reg <= 1'b0;
            cause_cnt_reg <= 10'h000;
         end else begin
            cause_cnt_reg <= cause_cnt_reg + 10'h001;
         end
      end
   end

   // Open-drain pin: only ever pulls low, released reads high.
   assign o_watchdog_cause_status_out = 1'b0;
   assign o_watchdog_cause_status_oe_n = !cause_low_reg;

   // AXI4-Lite write path; address and data are caught in either order.
   assign o_awready = !aw_full_reg && !o_bvalid;
   assign o_wready = !w_full_reg && !o_bvalid;
   assign wr_fire = aw_full_reg && w_full_reg && !o_bvalid;

   always @(posedge i_clock) begin
      if (i_rst) begin
         aw_full_reg <= 1'b0;
         w_full_reg <= 1'b0;
         aw_addr_reg <= 4'h0;
         w_data_reg <= 32'h00000000;
         w_strb_reg <= 4'h0;
         o_bvalid <= 1'b0;
         o_bresp <= `RGSEQ_RESP_OKAY;
         ctrl_reg <= `RGSEQ_CTRL_RST;
      end else begin
         if (i_awvalid && o_awready) begin
            aw_full_reg <= 1'b1;
            aw_addr_reg <= i_awaddr;
         end
         if (i_wvalid && o_wready) begin
            w_full_reg <= 1'b1;
            w_data_reg <= i_wdata;
            w_strb_reg <= i_wstrb;
         end
         if (wr_fire) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            o_bvalid <= 1'b1;
            case ({aw_addr_reg[3:2], 2'h0})
               `RGSEQ_CTRL_OFS: begin
                  o_bresp <= `RGSEQ_RESP_OKAY;
                  if (w_strb_reg[0]) begin
                     ctrl_reg <= w_data_reg[2:0];
                  end
               end
               `RGSEQ_STATUS_OFS: begin
                  o_bresp <= `RGSEQ_RESP_OKAY;
               end
               default: begin
                  o_bresp <= `RGSEQ_RESP_DECERR;
               end
            endcase
         end else if (o_bvalid && i_bready) begin
            o_bvalid <= 1'b0;
         end
      end
   end

   // Status word gathers the live protection and sequencer state.
   assign status_word = {22'h000000, state_reg, 1'b0, pend_ldo_reg, pend_buck_reg,
                         cause_low_reg, o_ldo_en, o_buck_switch_en, uvlo_reg, tsd_reg};

   // AXI4-Lite read path: one outstanding read, answered the cycle after it is taken.
   assign o_arready = !o_rvalid;

   always @(posedge i_clock) begin
      if (i_rst) begin
         o_rvalid <= 1'b0;
         o_rdata <= 32'h00000000;
         o_rresp <= `RGSEQ_RESP_OKAY;
      end else if (i_arvalid && o_arready) begin
         o_rvalid <= 1'b1;
         case ({i_araddr[3:2], 2'h0})
            `RGSEQ_CTRL_OFS: begin
               o_rdata <= {29'h00000000, ctrl_reg};
               o_rresp <= `RGSEQ_RESP_OKAY;
            end
            `RGSEQ_STATUS_OFS: begin
               o_rdata <= status_word;
               o_rresp <= `RGSEQ_RESP_OKAY;
            end
            default: begin
               o_rdata <= 32'h00000000;
               o_rresp <= `RGSEQ_RESP_DECERR;
            end
         endcase
      end else if (o_rvalid && i_rready) begin
         o_rvalid <= 1'b0;
      end
   end
endmodule // rgseq_top

// ### verification/rgseq_proc_model.sv
// Processor-side model that drives the enable and mode pins.
`timescale 1ns/100ps
module rgseq_proc_model (
   input wire i_clock,
   input wire i_rst,
   input wire i_buck_req,
   input wire i_ldo_req,
   input wire i_mode_req,
   output reg o_buck_enable_pin,
   output reg o_ldo_enable_pin,
   output reg o_mode_pin
);
   // A port pin of the processor changes just after a rising edge.
   always @(posedge i_clock) begin
      o_buck_enable_pin <= i_buck_req && !i_rst;
      o_ldo_enable_pin <= i_ldo_req && !i_rst;
      o_mode_pin <= i_mode_req && !i_rst;
   end
endmodule // rgseq_proc_model

// ### verification/rgseq_top_properties.sv
// Concurrent checks on the regulator sequencer ports.
`timescale 1ns/100ps
module rgseq_chk (
   input wire i_clock,
   input wire i_rst,
   input wire i_buck_enable_pin,
   input wire i_temp_above_150,
   input wire i_supply_below_2v15,
   input wire i_supply_below_3v65,
   input wire i_wd1_timeout,
   input wire i_wd2_power_cycle,
   input wire o_buck_switch_en,
   input wire o_buck_rectifier_en,
   input wire o_buck_forced_pwm,
   input wire o_buck_power_save_operation,
   input wire o_buck_soft_start,
   input wire o_ldo_en,
   input wire o_ldo_soft_start,
   input wire o_watchdog_cause_status_oe_n
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_rst);
   sequence s_both_off;
      !o_buck_switch_en && !o_ldo_en;
   endsequence
   sequence s_long_wd;
      i_wd2_power_cycle;
   endsequence
   // The shutdown flag is registered and then the outputs, so they drop on the second edge.
   a_hot_all_off: assert property (i_temp_above_150 |-> ##2 s_both_off)
      else $error("regulator on while hot");
   // Both comparators below means lockout whichever level the variant selects.
   a_lockout_off: assert property ((i_supply_below_2v15 && i_supply_below_3v65) [*3] |=>
      s_both_off) else $error("regulator on in lockout");
   a_cycle_off: assert property (s_long_wd |-> ##2 s_both_off [*8])
      else $error("regulator on in power cycle");
   a_cause_long: assert property (s_long_wd |=> !o_watchdog_cause_status_oe_n)
      else $error("cause pin not low");
   a_cause_short: assert property (i_wd1_timeout && !i_wd2_power_cycle |=>
      o_watchdog_cause_status_oe_n) else $error("cause pin not high");
   a_pin_off: assert property (!i_buck_enable_pin |=> !o_buck_switch_en)
      else $error("buck on with pin low");
   a_rect_pair: assert property (o_buck_rectifier_en == o_buck_switch_en)
      else $error("rectifier differs from switch");
   a_mode_split: assert property ((o_buck_forced_pwm || o_buck_power_save_operation) ==
      o_buck_switch_en && !(o_buck_forced_pwm && o_buck_power_save_operation))
      else $error("buck mode outputs inconsistent");
   a_soft_pulse: assert property (o_buck_soft_start |=> !o_buck_soft_start)
      else $error("buck soft start too long");
   a_ldo_soft: assert property ($rose(o_ldo_en) |-> ##[0:1] o_ldo_soft_start)
      else $error("ldo started without soft start");
endmodule // rgseq_chk
bind rgseq_top rgseq_chk chk_u (.i_clock, .i_rst, .i_buck_enable_pin, .i_temp_above_150,
   .i_supply_below_2v15, .i_supply_below_3v65, .i_wd1_timeout, .i_wd2_power_cycle,
   .o_buck_switch_en,
   .o_buck_rectifier_en, .o_buck_forced_pwm, .o_buck_power_save_operation, .o_buck_soft_start,
   .o_ldo_en, .o_ldo_soft_start, .o_watchdog_cause_status_oe_n);

// ### verification/rgseq_top_test.sv
// Self-checking bench for the regulator enable sequencer.
`timescale 1ns/100ps
`include "rgseq_regs.vh"
module rgseq_top_test;
   localparam int TK = 10;
   logic i_clock = 0, i_rst = 1, breq = 0, lreq = 0, mreq = 0;
   logic hot = 0, cool = 1, uv = 0, uvh = 0, wd1 = 0, wd2 = 0;
   logic [3:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rd;
   logic [1:0] rs;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   wire bpin, lpin, mpin, awready, wready, bvalid, arready, rvalid;
   wire sw, rect, fpwm, psave, bss, len, lss, st_oe_n, st_out;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   int fails = 0, n_checks = 0, cyc = 0, tb_on, tl_on, n;
   rgseq_proc_model proc_u (.i_clock(i_clock), .i_rst(i_rst), .i_buck_req(breq),
      .i_ldo_req(lreq), .i_mode_req(mreq), .o_buck_enable_pin(bpin),
      .o_ldo_enable_pin(lpin), .o_mode_pin(mpin));
   rgseq_top #(.TICK_CYCLES(TK)) dut_u (.i_clock(i_clock), .i_rst(i_rst),
      .i_buck_enable_pin(bpin), .i_ldo_enable_pin(lpin), .i_mode_pin(mpin),
      .i_temp_above_150(hot), .i_temp_below_130(cool), .i_supply_below_2v15(uv),
      .i_supply_below_3v65(uvh), .i_wd1_timeout(wd1), .i_wd2_power_cycle(wd2),
      .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
      .i_wstrb(4'hf), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
      .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
      .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
      .i_rready(rready), .o_buck_switch_en(sw), .o_buck_rectifier_en(rect),
      .o_buck_forced_pwm(fpwm), .o_buck_power_save_operation(psave),
      .o_buck_soft_start(bss), .o_ldo_en(len), .o_ldo_soft_start(lss),
      .o_watchdog_cause_status_out(st_out), .o_watchdog_cause_status_oe_n(st_oe_n));
   initial begin
      forever #10 i_clock = ~i_clock;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic end_sim;
      if (fails == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic wt(input int k);
      repeat (k) @(posedge i_clock);
      @(negedge i_clock);
   endtask
   // Ready is sampled mid-cycle, so the decision matches the next rising edge.
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw_p, w_p, aw_h, w_h;
      aw_p = 1;
      w_p = 1;
      @(posedge i_clock);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      while (aw_p || w_p) begin
         @(negedge i_clock);
         aw_h = aw_p && awready;
         w_h = w_p && wready;
         @(posedge i_clock);
         if (aw_h) begin
            awvalid <= 0;
            aw_p = 0;
         end
         if (w_h) begin
            wvalid <= 0;
            w_p = 0;
         end
      end
      do @(negedge i_clock); while (bvalid !== 1'b1);
      r = bresp;
      @(posedge i_clock);
      bready <= 0;
   endtask
   task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge i_clock);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      do @(negedge i_clock); while (arready !== 1'b1);
      @(posedge i_clock);
      arvalid <= 0;
      do @(negedge i_clock); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      @(posedge i_clock);
      rready <= 0;
   endtask
   always @(posedge i_clock) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         fails++;
         end_sim();
      end
   end
   initial begin
      repeat (10) @(posedge i_clock);
      i_rst <= 0;
      wt(1);
      chk(32'({sw, len, st_oe_n}), 32'h1);
      axi_rd(`RGSEQ_CTRL_OFS, rd, rs);
      chk(rd, 32'h0);
      axi_wr(`RGSEQ_CTRL_OFS, 32'h5, rs);
      chk(32'(rs), 32'(`RGSEQ_RESP_OKAY));
      axi_rd(`RGSEQ_CTRL_OFS, rd, rs);
      chk(rd, 32'h5);
      axi_wr(4'h8, 32'h7, rs);
      chk(32'(rs), 32'(`RGSEQ_RESP_DECERR));
      axi_rd(4'h8, rd, rs);
      chk(rd, 32'h0);
      chk(32'(rs), 32'(`RGSEQ_RESP_DECERR));
      @(posedge i_clock);
      breq <= 1;
      wt(3);
      chk(32'({sw, rect, len, fpwm, psave}), 32'h19);
      @(posedge i_clock);
      lreq <= 1;
      mreq <= 1;
      wt(3);
      chk(32'({sw, len, fpwm, psave}), 32'he);
      @(posedge i_clock);
      hot <= 1;
      cool <= 0;
      wt(2);
      chk(32'({sw, len}), 32'h0);
      // A write to the status word is accepted and ignored; only the shutdown bit is set.
      axi_wr(`RGSEQ_STATUS_OFS, 32'hffffffff, rs);
      chk(32'(rs), 32'(`RGSEQ_RESP_OKAY));
      axi_rd(`RGSEQ_STATUS_OFS, rd, rs);
      chk(rd, 32'h1);
      chk(32'(rs), 32'(`RGSEQ_RESP_OKAY));
      @(posedge i_clock);
      hot <= 0;
      wt(5);
      chk(32'({sw, len}), 32'h0);
      @(posedge i_clock);
      cool <= 1;
      n = 0;
      repeat (6) begin
         @(negedge i_clock);
         n += bss + lss;
      end
      chk(32'(n), 32'h2);
      @(posedge i_clock);
      uv <= 1;
      uvh <= 1;
      wt(4);
      chk(32'({sw, rect, len}), 32'h0);
      @(posedge i_clock);
      uv <= 0;
      wt(4);
      chk(32'({sw, len}), 32'h0);
      axi_wr(`RGSEQ_CTRL_OFS, 32'h0, rs);
      wt(4);
      chk(32'({sw, len}), 32'h3);
      @(posedge i_clock);
      uvh <= 0;
      for (int c = 0; c < 4; c++) begin
         axi_wr(`RGSEQ_CTRL_OFS, 32'(c), rs);
         @(posedge i_clock);
         wd2 <= 1;
         @(posedge i_clock);
         wd2 <= 0;
         wt(2);
         chk(32'({st_out, st_oe_n}), 32'h0);
         tb_on = -1;
         tl_on = -1;
         for (n = 0; n < 200 && (tb_on < 0 || tl_on < 0); n++) begin
            @(negedge i_clock);
            if (sw && tb_on < 0) tb_on = n;
            if (len && tl_on < 0) tl_on = n;
         end
         chk(32'(tb_on - tl_on), 32'(c == 0 ? 2 * TK : c == 3 ? 0 : -2 * TK));
      end
      @(posedge i_clock);
      wd2 <= 1;
      @(posedge i_clock);
      wd2 <= 0;
      n = 0;
      while (!st_oe_n && n < 20000) begin
         @(negedge i_clock);
         n++;
      end
      chk(32'(n >= 1000 * TK - 10 && n <= 1000 * TK + 10), 32'h1);
      @(posedge i_clock);
      wd2 <= 1;
      @(posedge i_clock);
      wd2 <= 0;
      wd1 <= 1;
      @(posedge i_clock);
      wd1 <= 0;
      wt(0);
      chk(32'(st_oe_n), 32'h1);
      end_sim();
   end
endmodule // rgseq_top_test
